// File: bench/fbec_src_model.sv
// source model for fetch, decode and branch events
`timescale 1ns/100ps
module fbec_src_model
  import fbec_pkg::*;
(
  input wire logic clk,
  output fbec_fetch_t fetch_ev,
  output logic queue_full,
  output logic fetch_req,
  output fbec_instr_t instr,
  output fbec_mode_t mode,
  output fbec_branch_t [BR_LANES-1:0] br
);
  initial begin
    fetch_ev = '0;
    queue_full = 1'b0;
    fetch_req = 1'b1;
    instr = '0;
    mode = FBEC_MODE_REAL;
    br = '0;
  end
  // one cycle of strobes, held until the next call
  task automatic put(input fbec_fetch_t f, input fbec_branch_t b1, input fbec_branch_t b0);
    @(negedge clk);
    fetch_ev = f;
    br = {b1, b0};
  endtask
  task automatic set_req(input logic v);
    @(negedge clk);
    fetch_req = v;
  endtask
  task automatic set_full(input logic v);
    @(negedge clk);
    queue_full = v;
  endtask
  // instruction valid for one edge, then released with scrambled fields
  task automatic offer(input fbec_instr_t i, input fbec_mode_t m);
    @(negedge clk);
    instr = i;
    mode = m;
    @(negedge clk);
    instr = {1'b0, ~i[3:0]};
  endtask
endmodule // fbec_src_model

// File: bench/test_frontend_branch_event_counter.sv
// self-checking bench for the front-end and branch event counter
`timescale 1ns/100ps
module test_frontend_branch_event_counter;
  import fbec_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] event_num = 8'h00;
  logic [7:0] unit_mask = 8'h00;
  logic count_clear = 1'b0;
  fbec_fetch_t fetch_ev;
  logic queue_full, fetch_req, fetch_go, decode_ready, decode_done;
  fbec_instr_t instr;
  fbec_mode_t mode;
  fbec_branch_t [BR_LANES-1:0] br;
  logic [CNT_W-1:0] event_count;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #4 sys_clk = ~sys_clk;
  fbec_src_model src (.clk(sys_clk), .fetch_ev(fetch_ev), .queue_full(queue_full),
    .fetch_req(fetch_req), .instr(instr), .mode(mode), .br(br));
  fbec_top #(.CW(CNT_W)) dut (.SYS_CLK(sys_clk), .NRST(nrst), .EVENT_NUM(event_num),
    .UNIT_MASK(unit_mask), .COUNT_CLEAR(count_clear), .FETCH_EV(fetch_ev),
    .QUEUE_FULL(queue_full), .FETCH_REQ(fetch_req), .DECODE_IN(instr), .CPU_MODE(mode),
    .BRANCH_EV(br), .FETCH_GO(fetch_go), .DECODE_READY(decode_ready),
    .DECODE_DONE(decode_done), .EVENT_COUNT(event_count));
  task automatic report_and_stop();
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk_cnt(input string n, input logic [CNT_W-1:0] e, input logic [CNT_W-1:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  // select an event and clear the counter
  task automatic arm(input logic [7:0] ev, input logic [7:0] um);
    @(negedge sys_clk);
    event_num = ev;
    unit_mask = um;
    count_clear = 1'b1;
    @(negedge sys_clk);
    count_clear = 1'b0;
  endtask
  task automatic fin(input int e, input string n);
    src.put('0, '0, '0);
    @(negedge sys_clk);
    chk_cnt(n, CNT_W'(e), event_count);
  endtask
  task automatic t_instr_translation_buffer();
    fbec_fetch_t f;
    logic [7:0] ums [5];
    int exp [5];
    ums = '{UM_MISS, UM_SMALL, UM_LARGE, UM_FLUSH, 8'h01};
    exp = '{4, 2, 2, 2, 0};
    f = '0;
    f.tlb_flush = 1'b1;
    f.tlb_miss_small = 1'b1;
    f.tlb_miss_large = 1'b1;
    for (int k = 0; k < 5; k++) begin
      arm(EV_INSTR_TRANSLATION_BUFFER, ums[k]);
      src.put(f, '0, '0);
      src.put(f, '0, '0);
      fin(exp[k], "tlb count");
    end
  endtask
  task automatic t_queue();
    arm(EV_QFULL, UM_QFULL);
    src.set_full(1'b1);
    @(negedge sys_clk);
    chk_bit("fetch go", 1'b0, fetch_go);
    repeat (2) @(negedge sys_clk);
    src.set_full(1'b0);
    @(negedge sys_clk);
    chk_bit("fetch go", 1'b1, fetch_go);
    src.set_req(1'b0);
    @(negedge sys_clk);
    chk_bit("fetch go idle", 1'b0, fetch_go);
    src.set_req(1'b1);
    fin(4, "queue full count");
  endtask
  task automatic t_stall();
    arm(EV_FSTALL, UM_NONE);
    src.put(7'h08, '0, '0);
    src.put(7'h04, '0, '0);
    src.put(7'h02, '0, '0);
    src.put(7'h0E, '0, '0);
    src.put(7'h40, '0, '0);
    fin(4, "stall count");
  endtask
  task automatic decode(input fbec_instr_t i, input fbec_mode_t m, output int lat);
    repeat (3) @(negedge sys_clk);
    src.offer(i, m);
    lat = 1;
    while (decode_done !== 1'b1 && lat < 20) begin
      @(negedge sys_clk);
      lat++;
    end
  endtask
  task automatic t_slow();
    fbec_instr_t ins [7];
    fbec_mode_t md [7];
    int exp [7];
    int lat0, lat, want;
    ins = '{5'h13, 5'h1A, 5'h15, 5'h15, 5'h15, 5'h15, 5'h15};
    md = '{FBEC_MODE_REAL, FBEC_MODE_PROT32, FBEC_MODE_REAL, FBEC_MODE_BIGREAL,
      FBEC_MODE_PROT16, FBEC_MODE_PROT32, FBEC_MODE_LONG};
    exp = '{0, 6, 6, 6, 6, 6, 0};
    arm(EV_SLOWLD, UM_NONE);
    decode(5'h19, FBEC_MODE_REAL, lat0);
    fin(0, "slow decode count");
    chk_cnt("decode latency", CNT_W'(FAST_DECODE_CYCLES), CNT_W'(lat0));
    for (int k = 0; k < 7; k++) begin
      arm(EV_SLOWLD, UM_NONE);
      decode(ins[k], md[k], lat);
      chk_bit("decode ready", exp[k] == 0, decode_ready);
      fin(exp[k], "slow decode count");
      want = (exp[k] == 0) ? FAST_DECODE_CYCLES : SLOW_DECODE_CYCLES;
      chk_cnt("decode latency", CNT_W'(want), CNT_W'(lat));
    end
  endtask
  task automatic t_branch();
    logic [7:0] evs [8];
    logic [7:0] ums [8];
    int exp [8];
    evs = '{EV_BR, EV_BRMIS, EV_BRDEC, EV_CND, EV_CNDMIS, EV_IND, EV_BR, 8'h84};
    ums = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    exp = '{3, 3, 1, 2, 2, 1, 0, 0};
    for (int k = 0; k < 8; k++) begin
      arm(evs[k], ums[k]);
      src.put(7'h01, 5'h13, 5'h15);
      src.put('0, 5'h15, 5'h1F);
      fin(exp[k], "branch count");
    end
  endtask
  // reset in mid-run, counter restarts from zero
  task automatic t_reset();
    arm(EV_BR, UM_NONE);
    src.put('0, 5'h10, 5'h10);
    @(negedge sys_clk);
    nrst = 1'b0;
    @(negedge sys_clk);
    chk_cnt("count in reset", '0, event_count);
    chk_bit("fetch go in reset", 1'b0, fetch_go);
    chk_bit("decode ready in reset", 1'b0, decode_ready);
    nrst = 1'b1;
    @(negedge sys_clk);
    chk_cnt("count after reset", CNT_W'(2), event_count);
    chk_bit("fetch go after reset", 1'b1, fetch_go);
    chk_bit("decode ready after reset", 1'b1, decode_ready);
    fin(4, "branch count after reset");
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    t_instr_translation_buffer();
    t_queue();
    t_stall();
    t_slow();
    t_branch();
    t_reset();
    report_and_stop();
  end
endmodule // test_frontend_branch_event_counter

// File: include/fbec_pkg.sv
// package with event encodings, front-end and branch event types for the event counter
package fbec_pkg;
  localparam logic [7:0] EV_INSTR_TRANSLATION_BUFFER = 8'h82;
  localparam logic [7:0] EV_QFULL = 8'h83;
  localparam logic [7:0] EV_FSTALL = 8'h86;
  localparam logic [7:0] EV_SLOWLD = 8'h87;
  localparam logic [7:0] EV_BR = 8'h88;
  localparam logic [7:0] EV_BRMIS = 8'h89;
  localparam logic [7:0] EV_BRDEC = 8'h8A;
  localparam logic [7:0] EV_CND = 8'h8B;
  localparam logic [7:0] EV_CNDMIS = 8'h8C;
  localparam logic [7:0] EV_IND = 8'h8D;
  localparam logic [7:0] UM_FLUSH = 8'h40;
  localparam logic [7:0] UM_MISS = 8'h12;
  localparam logic [7:0] UM_SMALL = 8'h02;
  localparam logic [7:0] UM_LARGE = 8'h10;
  localparam logic [7:0] UM_QFULL = 8'h02;
  localparam logic [7:0] UM_NONE = 8'h00;
  localparam logic [7:0] PFX_OPSIZE = 8'h66;
  localparam logic [7:0] PFX_ADSIZE = 8'h67;
  localparam int SLOW_DECODE_CYCLES = 6;
  localparam int FAST_DECODE_CYCLES = 1;
  localparam int BR_LANES = 2;
  localparam int CNT_W = 48;

  // operating mode of the decoder
  typedef enum logic [2:0] {
    FBEC_MODE_REAL, FBEC_MODE_BIGREAL, FBEC_MODE_PROT16, FBEC_MODE_PROT32, FBEC_MODE_LONG
  } fbec_mode_t;

  // one executed branch from a lane
  typedef struct packed {
    logic valid;
    logic uop_only;
    logic cond;
    logic indirect;
    logic mispred;
  } fbec_branch_t;

  // fetch side event strobes
  typedef struct packed {
    logic tlb_flush;
    logic tlb_miss_small;
    logic tlb_miss_large;
    logic cache_miss_stall;
    logic tlb_miss_stall;
    logic tlb_fault_stall;
    logic decode_mispred;
  } fbec_fetch_t;

  // instruction offered to the length decoder
  typedef struct packed {
    logic valid;
    logic has_opsize_pfx;
    logic has_adsize_pfx;
    logic has_imm;
    logic has_modrm;
  } fbec_instr_t;
endpackage

// File: verilog/fbec_event_select.sv
// event number and unit mask decode into an increment value
`timescale 1ns/100ps
module fbec_event_select
  import fbec_pkg::*;
(
  input wire logic [7:0] ev_num,
  input wire logic [7:0] umask,
  input wire logic tlb_flush,
  input wire logic miss_small,
  input wire logic miss_large,
  input wire logic qfull,
  input wire logic fstall,
  input wire logic slow_ld,
  input wire logic decode_mispred,
  input wire logic [1:0] n_br,
  input wire logic [1:0] n_brmis,
  input wire logic [1:0] n_cnd,
  input wire logic [1:0] n_cndmis,
  input wire logic [1:0] n_ind,
  output logic [2:0] inc
);
  function automatic logic [2:0] w(input logic b);
    w = {2'b00, b};
  endfunction
  wire is_instr_translation_buffer = (ev_num == EV_INSTR_TRANSLATION_BUFFER);
  always_comb begin
    inc = 3'd0;
    if (is_instr_translation_buffer && umask == UM_FLUSH) inc = w(tlb_flush);
    else if (is_instr_translation_buffer && umask == UM_MISS) inc = w(miss_small) + w(miss_large);
    else if (is_instr_translation_buffer && umask == UM_SMALL) inc = w(miss_small);
    else if (is_instr_translation_buffer && umask == UM_LARGE) inc = w(miss_large);
    else if (ev_num == EV_QFULL && umask == UM_QFULL) inc = w(qfull);
    else if (ev_num == EV_FSTALL && umask == UM_NONE) inc = w(fstall);
    else if (ev_num == EV_SLOWLD && umask == UM_NONE) inc = w(slow_ld);
    else if (ev_num == EV_BR && umask == UM_NONE) inc = {1'b0, n_br};
    else if (ev_num == EV_BRMIS && umask == UM_NONE) inc = {1'b0, n_brmis};
    else if (ev_num == EV_BRDEC && umask == UM_NONE) inc = w(decode_mispred);
    else if (ev_num == EV_CND && umask == UM_NONE) inc = {1'b0, n_cnd};
    else if (ev_num == EV_CNDMIS && umask == UM_NONE) inc = {1'b0, n_cndmis};
    else if (ev_num == EV_IND && umask == UM_NONE) inc = {1'b0, n_ind};
  end
endmodule // fbec_event_select

// File: verilog/fbec_length_decoder.sv
// length decoder timing model, one cycle normal, six cycles slow path
`timescale 1ns/100ps
module fbec_length_decoder
  import fbec_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire fbec_instr_t instr,
  input wire fbec_mode_t mode,
  output logic ready,
  output logic done,
  output logic slow_busy
);
  typedef enum logic [0:0] {FBEC_LD_IDLE, FBEC_LD_SLOW} fbec_ld_t;
  fbec_ld_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  wire legacy_mode = (mode == FBEC_MODE_REAL) || (mode == FBEC_MODE_BIGREAL) ||
                     (mode == FBEC_MODE_PROT16) || (mode == FBEC_MODE_PROT32);
  wire slow_op = instr.has_opsize_pfx && instr.has_imm;
  wire slow_ad = instr.has_adsize_pfx && instr.has_modrm && legacy_mode;
  wire need_slow = instr.valid && (slow_op || slow_ad);
  assign ready = (state_q == FBEC_LD_IDLE);
  assign slow_busy = (state_q == FBEC_LD_SLOW) || (ready && need_slow);
  assign done = ready ? (instr.valid && !need_slow) :
                (cnt_q == 3'(SLOW_DECODE_CYCLES - 1));

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      FBEC_LD_IDLE: begin
        if (need_slow) begin
          state_d = FBEC_LD_SLOW;
          cnt_d = 3'd1;
        end
      end
      FBEC_LD_SLOW: begin
        if (cnt_q == 3'(SLOW_DECODE_CYCLES - 1)) begin
          state_d = FBEC_LD_IDLE;
          cnt_d = 3'd0;
        end else begin
          cnt_d = cnt_q + 3'd1;
        end
      end
      default: begin
        state_d = FBEC_LD_IDLE;
        cnt_d = 3'd0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= FBEC_LD_IDLE;
      cnt_q <= 3'd0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  sequence slow_start_s;
    ready && need_slow;
  endsequence
  sequence slow_run_s;
    slow_busy [*6] ##1 ready;
  endsequence
  slow_len_a: assert property (@(posedge clk) disable iff (!nrst)
    slow_start_s |-> slow_run_s) else $error("slow decode not six cycles");
  fast_done_a: assert property (@(posedge clk) disable iff (!nrst)
    (ready && instr.valid && !need_slow) |-> done ##1 ready)
    else $error("fast decode not one cycle");
  opsz_slow_a: assert property (@(posedge clk) disable iff (!nrst)
    (ready && instr.valid && instr.has_opsize_pfx && instr.has_imm) |-> ##1 !ready)
    else $error("opsize prefix did not take slow path");
  adsz_slow_a: assert property (@(posedge clk) disable iff (!nrst)
    (ready && instr.valid && instr.has_adsize_pfx && instr.has_modrm &&
     (mode inside {FBEC_MODE_REAL, FBEC_MODE_BIGREAL, FBEC_MODE_PROT16, FBEC_MODE_PROT32}))
    |-> ##1 !ready) else $error("address prefix did not take slow path");
  adsz_long_a: assert property (@(posedge clk) disable iff (!nrst)
    (ready && instr.valid && instr.has_adsize_pfx && !instr.has_opsize_pfx &&
     mode == FBEC_MODE_LONG) |-> done ##1 ready)
    else $error("address prefix slowed long mode decode");
endmodule // fbec_length_decoder

// File: verilog/fbec_top.sv
// front-end and branch event counter top
`timescale 1ns/100ps
module fbec_top
  import fbec_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic [7:0] EVENT_NUM,
  input wire logic [7:0] UNIT_MASK,
  input wire logic COUNT_CLEAR,
  input wire fbec_fetch_t FETCH_EV,
  input wire logic QUEUE_FULL,
  input wire logic FETCH_REQ,
  input wire fbec_instr_t DECODE_IN,
  input wire fbec_mode_t CPU_MODE,
  input wire fbec_branch_t [BR_LANES-1:0] BRANCH_EV,
  output logic FETCH_GO,
  output logic DECODE_READY,
  output logic DECODE_DONE,
  output logic [CW-1:0] EVENT_COUNT
);
  function automatic logic [1:0] pop2(input logic [BR_LANES-1:0] v);
    pop2 = 2'(v[0]) + 2'(v[1]);
  endfunction

  logic [CW-1:0] count_q, count_d;
  logic fetch_go_q, ld_ready, ld_done, ld_slow;
  logic dec_ready_q, dec_done_q;
  logic [2:0] inc;
  logic [BR_LANES-1:0] br_v, mis_v, cnd_v, cndmis_v, ind_v;

  // real instructions only, micro-op branches dropped
  genvar g;
  generate
    for (g = 0; g < BR_LANES; g++) begin : g_lane
      assign br_v[g] = BRANCH_EV[g].valid && !BRANCH_EV[g].uop_only;
      assign mis_v[g] = br_v[g] && BRANCH_EV[g].mispred;
      assign cnd_v[g] = br_v[g] && BRANCH_EV[g].cond;
      assign cndmis_v[g] = cnd_v[g] && BRANCH_EV[g].mispred;
      assign ind_v[g] = br_v[g] && BRANCH_EV[g].indirect;
    end
  endgenerate

  wire fstall = FETCH_EV.cache_miss_stall || FETCH_EV.tlb_miss_stall ||
                FETCH_EV.tlb_fault_stall;
  wire fetch_go_d = FETCH_REQ && !QUEUE_FULL;

  fbec_length_decoder u_ld (
    .clk(SYS_CLK),
    .nrst(NRST),
    .instr(DECODE_IN),
    .mode(CPU_MODE),
    .ready(ld_ready),
    .done(ld_done),
    .slow_busy(ld_slow)
  );

  fbec_event_select u_sel (
    .ev_num(EVENT_NUM),
    .umask(UNIT_MASK),
    .tlb_flush(FETCH_EV.tlb_flush),
    .miss_small(FETCH_EV.tlb_miss_small),
    .miss_large(FETCH_EV.tlb_miss_large),
    .qfull(QUEUE_FULL),
    .fstall(fstall),
    .slow_ld(ld_slow),
    .decode_mispred(FETCH_EV.decode_mispred),
    .n_br(pop2(br_v)),
    .n_brmis(pop2(mis_v)),
    .n_cnd(pop2(cnd_v)),
    .n_cndmis(pop2(cndmis_v)),
    .n_ind(pop2(ind_v)),
    .inc(inc)
  );

  assign count_d = COUNT_CLEAR ? '0 : count_q + CW'(inc);

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      count_q <= '0;
      fetch_go_q <= 1'b0;
      dec_ready_q <= 1'b0;
      dec_done_q <= 1'b0;
    end else begin
      count_q <= count_d;
      fetch_go_q <= fetch_go_d;
      dec_ready_q <= ld_ready;
      dec_done_q <= ld_done;
    end
  end

  assign FETCH_GO = fetch_go_q;
  assign DECODE_READY = dec_ready_q;
  assign DECODE_DONE = dec_done_q;
  assign EVENT_COUNT = count_q;

  wire sel_qfull = EVENT_NUM == EV_QFULL && UNIT_MASK == UM_QFULL;
  wire sel_flush = EVENT_NUM == EV_INSTR_TRANSLATION_BUFFER && UNIT_MASK == UM_FLUSH;
  wire sel_miss = EVENT_NUM == EV_INSTR_TRANSLATION_BUFFER && UNIT_MASK == UM_MISS;
  wire sel_br = EVENT_NUM == EV_BR && UNIT_MASK == UM_NONE;
  wire sel_ind = EVENT_NUM == EV_IND && UNIT_MASK == UM_NONE;
  wire sel_small = EVENT_NUM == EV_INSTR_TRANSLATION_BUFFER && UNIT_MASK == UM_SMALL;
  wire sel_large = EVENT_NUM == EV_INSTR_TRANSLATION_BUFFER && UNIT_MASK == UM_LARGE;
  wire sel_fstall = EVENT_NUM == EV_FSTALL && UNIT_MASK == UM_NONE;
  wire sel_brdec = EVENT_NUM == EV_BRDEC && UNIT_MASK == UM_NONE;
  wire sel_cnd = EVENT_NUM == EV_CND && UNIT_MASK == UM_NONE;
  wire sel_plain = UNIT_MASK == UM_NONE && (EVENT_NUM inside {EV_FSTALL, EV_SLOWLD, EV_BR,
                   EV_BRMIS, EV_BRDEC, EV_CND, EV_CNDMIS, EV_IND});
  wire sel_listed = sel_flush || sel_miss || sel_small || sel_large || sel_qfull || sel_plain;

  qfull_count_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (sel_qfull && QUEUE_FULL && !COUNT_CLEAR) |=> EVENT_COUNT == $past(count_q) + 1)
    else $error("queue full cycle not counted");
  fetch_stop_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    QUEUE_FULL |=> !FETCH_GO) else $error("fetch while queue full");
  flush_count_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (sel_flush && !COUNT_CLEAR) |=> EVENT_COUNT == $past(count_q) + $past(CW'(FETCH_EV.tlb_flush)))
    else $error("tlb flush count wrong");
  miss_both_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (sel_miss && FETCH_EV.tlb_miss_small && FETCH_EV.tlb_miss_large && !COUNT_CLEAR)
    |=> EVENT_COUNT == $past(count_q) + 2) else $error("tlb misses not summed");
  uop_skip_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (sel_br && !COUNT_CLEAR && (BRANCH_EV[0].uop_only || !BRANCH_EV[0].valid) &&
     (BRANCH_EV[1].uop_only || !BRANCH_EV[1].valid)) |=> $stable(EVENT_COUNT))
    else $error("micro-op branch counted");
  ind_count_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (sel_ind && !COUNT_CLEAR) |=> EVENT_COUNT == $past(count_q) + CW'($past(pop2(ind_v))))
    else $error("indirect branch count wrong");
  unlisted_hold_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (!sel_listed && !COUNT_CLEAR) |=> $stable(EVENT_COUNT)) else $error("unlisted event counted");
  stall_count_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (sel_fstall && !COUNT_CLEAR && (FETCH_EV.cache_miss_stall || FETCH_EV.tlb_miss_stall ||
     FETCH_EV.tlb_fault_stall)) |=> EVENT_COUNT == $past(count_q) + 1)
    else $error("fetch stall cycle not counted");
  small_miss_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (sel_small && !COUNT_CLEAR)
    |=> EVENT_COUNT == $past(count_q) + $past(CW'(FETCH_EV.tlb_miss_small)))
    else $error("small page miss count wrong");
  large_miss_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (sel_large && !COUNT_CLEAR)
    |=> EVENT_COUNT == $past(count_q) + $past(CW'(FETCH_EV.tlb_miss_large)))
    else $error("large page miss count wrong");
  decode_mis_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (sel_brdec && !COUNT_CLEAR)
    |=> EVENT_COUNT == $past(count_q) + $past(CW'(FETCH_EV.decode_mispred)))
    else $error("decode mispredict count wrong");
  cnd_count_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (sel_cnd && !COUNT_CLEAR) |=> EVENT_COUNT == $past(count_q) + CW'(
      $past(2'(BRANCH_EV[0].valid && !BRANCH_EV[0].uop_only && BRANCH_EV[0].cond)) +
      $past(2'(BRANCH_EV[1].valid && !BRANCH_EV[1].uop_only && BRANCH_EV[1].cond))))
    else $error("conditional branch count wrong");
  slow_cycle_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (EVENT_NUM == EV_SLOWLD && UNIT_MASK == UM_NONE && !COUNT_CLEAR && ld_slow)
    |=> EVENT_COUNT == $past(count_q) + 1) else $error("slow decode cycle not counted");
endmodule // fbec_top
